// File: remote_peer.sv
module remote_peer (
  input  wire logic aclk,
  input  wire logic rts_n,
  output logic      cts_n,
  output logic      xonoff_received,
  output logic      special_received,
  output logic      remote_terminate,
  output logic      flow_msg_sent_dtr_off
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cts_n, xonoff_received, special_received} = 3'b000;
  initial {remote_terminate, flow_msg_sent_dtr_off} = 2'b00;
  task automatic send_char(input logic special);
    for (int n = 0; n < 20 && rts_n; n++) @(posedge aclk);
    @(posedge aclk);
    if (special) special_received <= 1'b1;
    else xonoff_received <= 1'b1;
    @(posedge aclk);
    {xonoff_received, special_received} <= 2'b00;
  endtask : send_char
  task automatic set_lines(input logic [2:0] l);
    @(posedge aclk);
    {cts_n, remote_terminate, flow_msg_sent_dtr_off} <= l;
  endtask : set_lines
endmodule : remote_peer

// File: uart_flow_monitor.sv
module uart_flow_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        remote_terminate,
  input wire logic        cts_n,
  input wire logic        tx_hold,
  input wire logic        rts_n,
  input wire logic        irq,
  input wire logic [1:0]  rresp,
  input wire logic [11:0] araddr,
  input wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_w_taken; awvalid && awready && wvalid && wready; endsequence
  sequence ar_taken; arvalid && arready; endsequence
  logic mapped;
  assign mapped = araddr[1:0] == 2'h0 &&
                  araddr[11:2] inside {[10'h00e:10'h015], [10'h020:10'h022]};
  a_write_answer: assert property (aw_w_taken |-> ##[1:2] bvalid)
    else $error("write not answered");
  a_read_answer: assert property (ar_taken |=> rvalid)
    else $error("read not answered");
  a_read_blocks: assert property (rvalid |-> !arready)
    else $error("address taken during read");
  a_data_width: assert property (ar_taken |=> rdata[31:8] == 24'h0)
    else $error("upper data bits set");
  a_unmapped_err: assert property ((ar_taken ##0 !mapped) |=>
    rresp == uart_flow_pkg::resp_slverr && rdata == 32'h0) else $error("bad unmapped read");
  a_mapped_okay: assert property ((ar_taken ##0 mapped) |=>
    rresp == uart_flow_pkg::resp_okay) else $error("bad mapped response");
  a_term_hold: assert property (remote_terminate |-> ##[1:2] tx_hold)
    else $error("terminate not holding");
  a_hold_cause: assert property ($rose(tx_hold) |-> $past(cts_n || remote_terminate))
    else $error("hold without cause");
  a_reset_clear: assert property (disable iff (1'b0) !aresetn |=>
    !rvalid && !irq && !rts_n && !tx_hold) else $error("reset state wrong");
endmodule : uart_flow_monitor

bind uart_flow_regs uart_flow_monitor uart_flow_monitor_i (
  .aclk             (aclk),
  .aresetn          (aresetn),
  .awvalid          (awvalid),
  .awready          (awready),
  .wvalid           (wvalid),
  .wready           (wready),
  .bvalid           (bvalid),
  .arvalid          (arvalid),
  .arready          (arready),
  .rvalid           (rvalid),
  .remote_terminate (remote_terminate),
  .cts_n            (cts_n),
  .tx_hold          (tx_hold),
  .rts_n            (rts_n),
  .irq              (irq),
  .rresp            (rresp),
  .araddr           (araddr),
  .rdata            (rdata)
);

// File: uart_flow_pkg.sv
// Summary of operation
// - status bit 0 reads 1 while transmitter is held off by remote terminate
// - status bit 1 reads 1 after xoff or rts sent with dtr inactive
// - status bit 2 sets on received xon or xoff, cleared by read
// - xoff detect reaches interrupt status as level 6 when enabled
// - status bit 3 sets on special character, read clears, level 6 interrupt
// - tx trigger level register at 0x10, 8 bits, rw, resets zero
// - rx trigger level register at 0x11, 8 bits, rw, resets zero
// - flow low threshold at 0x12, rw, resets zero, releases hold-off
// - flow high threshold at 0x13, rw, resets zero, asserts hold-off
// - prescale bits 3:0 at 0x14 give n term, rw, reset zero
// - prescale bits 7:4 give m term, reset zero, software uses 0 to 2
// - offset 0x15 reads rx fill when select bit 4 set, else line-status fill
// - rx fill counter read-only, 8 bits, resets zero, shows rx fifo entries
// - line-status fill counter read-only, 8 bits, resets zero
// - enhanced auto rts drives rts inactive at high, releases below low
// - enhanced auto cts holds off transmit while cts inactive high
package uart_flow_pkg;
  localparam logic [11:0] off_second_xoff  = 12'h00e;
  localparam logic [11:0] off_adv_status   = 12'h00f;
  localparam logic [11:0] off_tx_trig      = 12'h010;
  localparam logic [11:0] off_rx_trig      = 12'h011;
  localparam logic [11:0] off_flow_low     = 12'h012;
  localparam logic [11:0] off_flow_high    = 12'h013;
  localparam logic [11:0] off_prescale     = 12'h014;
  localparam logic [11:0] off_fill_count   = 12'h015;
  localparam logic [11:0] off_irq_status   = 12'h020;
  localparam logic [11:0] off_irq_mask     = 12'h021;
  localparam logic [11:0] off_control      = 12'h022;
  localparam int          byte_addr_shift  = 2;
  localparam int          bit_terminate    = 0;
  localparam int          bit_remote_dis   = 1;
  localparam int          bit_xonoff_det   = 2;
  localparam int          bit_special_det  = 3;
  localparam int          ctl_enhanced     = 0;
  localparam int          ctl_auto_rts     = 1;
  localparam int          ctl_auto_cts     = 2;
  localparam int          ctl_level6_en    = 3;
  localparam int          ctl_fill_select  = 4;
  localparam logic [7:0]  reset_byte       = 8'h00;
  localparam logic [1:0]  resp_okay        = 2'h0;
  localparam logic [1:0]  resp_slverr      = 2'h2;
  // irq status bits: 0 tx level, 1 rx level, 2 xon/xoff, 3 special char
  localparam int          irq_tx_level     = 0;
  localparam int          irq_rx_level     = 1;
  localparam int          irq_xonoff       = 2;
  localparam int          irq_special      = 3;

  typedef enum logic [1:0] {wr_idle, wr_resp} wr_state_t;

  typedef struct packed {
    logic [7:0] second_xoff_character;
    logic [7:0] tx_irq_trigger_level;
    logic [7:0] rx_irq_trigger_level;
    logic [7:0] flow_low_threshold;
    logic [7:0] flow_high_threshold;
    logic [7:0] baud_prescale;
    logic [7:0] control;
    logic [3:0] irq_mask;
  } cfg_t;

  typedef struct packed {
    logic [7:0] rx_fill;
    logic [7:0] lsr_fill;
    logic [7:0] tx_fill;
  } fill_t;
endpackage : uart_flow_pkg

// File: uart_flow_regs.sv
// Added by the designer: the AXI4-Lite register port.
module uart_flow_regs (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [11:0]           awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [11:0]           araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire uart_flow_pkg::fill_t  fill,
  input  wire logic                  remote_terminate,
  input  wire logic                  flow_msg_sent_dtr_off,
  input  wire logic                  xonoff_received,
  input  wire logic                  special_received,
  input  wire logic                  cts_n,
  output logic                       rts_n,
  output logic                       tx_hold,
  output logic                       level6_irq,
  output logic [7:0]                 second_xoff_character,
  output logic [3:0]                 prescale_n_term,
  output logic [3:0]                 prescale_m_term,
  output logic                       irq
);

  typedef struct packed {
    uart_flow_pkg::cfg_t cfg;
    logic [3:0]          flags;
    logic [3:0]          irq_status;
    logic                aw_got;
    logic                w_got;
    logic [11:0]         aw_addr;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic                rts_n;
    logic                tx_hold;
    logic                level6_irq;
    logic                irq;
  } state_t;

  state_t s_reg;
  state_t s_next;

  function automatic logic [9:0] word_index(input logic [11:0] a);
    word_index = a[11:2];
  endfunction : word_index

  function automatic logic known(input logic [9:0] i);
    known = (i >= uart_flow_pkg::off_second_xoff[9:0] && i <= uart_flow_pkg::off_fill_count[9:0])
         || (i >= uart_flow_pkg::off_irq_status[9:0] && i <= uart_flow_pkg::off_control[9:0]);
  endfunction : known

  logic        enh;
  logic [7:0]  ctl;
  logic [7:0]  rdval;
  logic [9:0]  ridx;
  logic [9:0]  widx;
  logic        rd_fire;
  logic        rd_clear_flags;
  logic        rd_clear_irq;
  logic [3:0]  flags_set;
  logic [3:0]  irq_set;

  always_comb begin
    s_next = s_reg;
    ctl = s_reg.cfg.control;
    enh = ctl[uart_flow_pkg::ctl_enhanced];
    ridx = word_index(araddr);
    widx = word_index(s_reg.aw_addr);
    rd_fire = arvalid && s_reg.arready;
    rd_clear_flags = rd_fire && ridx == uart_flow_pkg::off_adv_status[9:0];
    rd_clear_irq = rd_fire && ridx == uart_flow_pkg::off_irq_status[9:0];
    flags_set = 4'h0;
    flags_set[uart_flow_pkg::bit_xonoff_det] = xonoff_received;
    flags_set[uart_flow_pkg::bit_special_det] = special_received;
    // read value
    rdval = 8'h00;
    case (ridx)
      uart_flow_pkg::off_second_xoff[9:0]: rdval = s_reg.cfg.second_xoff_character;
      uart_flow_pkg::off_adv_status[9:0]:  rdval = {4'h0, s_reg.flags};
      uart_flow_pkg::off_tx_trig[9:0]:     rdval = s_reg.cfg.tx_irq_trigger_level;
      uart_flow_pkg::off_rx_trig[9:0]:     rdval = s_reg.cfg.rx_irq_trigger_level;
      uart_flow_pkg::off_flow_low[9:0]:    rdval = s_reg.cfg.flow_low_threshold;
      uart_flow_pkg::off_flow_high[9:0]:   rdval = s_reg.cfg.flow_high_threshold;
      uart_flow_pkg::off_prescale[9:0]:    rdval = s_reg.cfg.baud_prescale;
      uart_flow_pkg::off_fill_count[9:0]:  rdval = ctl[uart_flow_pkg::ctl_fill_select]
                                                   ? fill.rx_fill : fill.lsr_fill;
      uart_flow_pkg::off_irq_status[9:0]:  rdval = {4'h0, s_reg.irq_status};
      uart_flow_pkg::off_irq_mask[9:0]:    rdval = {4'h0, s_reg.cfg.irq_mask};
      uart_flow_pkg::off_control[9:0]:     rdval = ctl;
      default:                             rdval = 8'h00;
    endcase
    // read channel
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
    if (rd_fire) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rdata = {24'h000000, rdval};
      s_next.rresp = known(ridx) ? uart_flow_pkg::resp_okay : uart_flow_pkg::resp_slverr;
    end
    // write channel
    if (awvalid && s_reg.awready) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = awaddr;
      s_next.awready = 1'b0;
    end
    if (wvalid && s_reg.wready) begin
      s_next.w_got = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
      s_next.wready = 1'b0;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.bvalid = 1'b1;
      s_next.bresp = known(widx) ? uart_flow_pkg::resp_okay : uart_flow_pkg::resp_slverr;
      if (s_reg.w_strb[0]) begin
        case (widx)
          uart_flow_pkg::off_second_xoff[9:0]: s_next.cfg.second_xoff_character = s_reg.w_data[7:0];
          uart_flow_pkg::off_tx_trig[9:0]:     s_next.cfg.tx_irq_trigger_level = s_reg.w_data[7:0];
          uart_flow_pkg::off_rx_trig[9:0]:     s_next.cfg.rx_irq_trigger_level = s_reg.w_data[7:0];
          uart_flow_pkg::off_flow_low[9:0]:    s_next.cfg.flow_low_threshold = s_reg.w_data[7:0];
          uart_flow_pkg::off_flow_high[9:0]:   s_next.cfg.flow_high_threshold = s_reg.w_data[7:0];
          uart_flow_pkg::off_prescale[9:0]:    s_next.cfg.baud_prescale = s_reg.w_data[7:0];
          uart_flow_pkg::off_irq_mask[9:0]:    s_next.cfg.irq_mask = s_reg.w_data[3:0];
          uart_flow_pkg::off_control[9:0]:     s_next.cfg.control = {3'h0, s_reg.w_data[4:0]};
          default:                             s_next.cfg = s_reg.cfg;
        endcase
      end
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end
    // advanced status flags, set wins over read clear
    s_next.flags[uart_flow_pkg::bit_terminate] = remote_terminate;
    s_next.flags[uart_flow_pkg::bit_remote_dis] = flow_msg_sent_dtr_off;
    s_next.flags[3:2] = (rd_clear_flags ? 2'h0 : s_reg.flags[3:2]) | flags_set[3:2];
    // level 6 source
    s_next.level6_irq = ctl[uart_flow_pkg::ctl_level6_en]
                        && (s_next.flags[uart_flow_pkg::bit_xonoff_det]
                        || s_next.flags[uart_flow_pkg::bit_special_det]);
    // trigger level and received character events
    irq_set = 4'h0;
    irq_set[uart_flow_pkg::irq_tx_level] = fill.tx_fill <= s_reg.cfg.tx_irq_trigger_level;
    irq_set[uart_flow_pkg::irq_rx_level] = fill.rx_fill >= s_reg.cfg.rx_irq_trigger_level;
    irq_set[uart_flow_pkg::irq_xonoff] = xonoff_received;
    irq_set[uart_flow_pkg::irq_special] = special_received;
    s_next.irq_status = (rd_clear_irq ? 4'h0 : s_reg.irq_status) | irq_set;
    s_next.irq = |(s_next.irq_status & s_reg.cfg.irq_mask);
    // automatic flow control
    if (enh && ctl[uart_flow_pkg::ctl_auto_rts]) begin
      if (fill.rx_fill >= s_reg.cfg.flow_high_threshold) begin
        s_next.rts_n = 1'b1;
      end else if (fill.rx_fill < s_reg.cfg.flow_low_threshold) begin
        s_next.rts_n = 1'b0;
      end
    end else begin
      s_next.rts_n = 1'b0;
    end
    s_next.tx_hold = (enh && ctl[uart_flow_pkg::ctl_auto_cts] && cts_n) || remote_terminate;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bresp = s_reg.bresp;
  assign bvalid = s_reg.bvalid;
  assign arready = s_reg.arready;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign rvalid = s_reg.rvalid;
  assign rts_n = s_reg.rts_n;
  assign tx_hold = s_reg.tx_hold;
  assign level6_irq = s_reg.level6_irq;
  assign second_xoff_character = s_reg.cfg.second_xoff_character;
  assign prescale_n_term = s_reg.cfg.baud_prescale[3:0];
  assign prescale_m_term = s_reg.cfg.baud_prescale[7:4];
  assign irq = s_reg.irq;

endmodule : uart_flow_regs

// File: uart_flow_regs_tb_top.sv
module uart_flow_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, wvalid, bready;
  logic arvalid, rready, awready, wready, bvalid, arready, rvalid, e;
  logic rts_n, tx_hold, level6_irq, irq, remote_terminate, flow_msg_sent_dtr_off;
  logic xonoff_received, special_received, cts_n;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, prescale_n_term, prescale_m_term;
  logic [1:0] bresp, rresp, rs, bs;
  logic [7:0] second_xoff_character, v;
  uart_flow_pkg::fill_t fill;
  int mismatches = 0, tests_run = 0, r;
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  uart_flow_regs uart_flow_regs_i (.*);
  remote_peer remote_peer_i (.*);
  task automatic final_report();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic timeout();
    mismatches++;
    $display("ERROR %0t wait ran out", $time);
    final_report();
  endtask : timeout
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : settle
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    bit got;
    @(posedge aclk);
    awaddr <= idx << 2;
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'b111;
    got = 1'b0;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        bs = bresp;
      end
      got = bvalid;
    end
    if (!got) timeout();
  endtask : wr
  task automatic rc(input logic [11:0] idx, input logic [31:0] exp);
    bit got;
    @(posedge aclk);
    araddr <= idx << 2;
    {arvalid, rready} <= 2'b11;
    got = 1'b0;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
      end
      got = rvalid;
    end
    if (!got) timeout();
    check(rd, exp);
  endtask : rc
  function automatic logic exp_rts(input logic [7:0] l, input logic p);
    return l >= 8'h06 ? 1'b1 : (l < 8'h02 ? 1'b0 : p);
  endfunction : exp_rts
  initial begin
    logic [11:0] rw_idx [5] = '{12'h00e, 12'h010, 12'h011, 12'h012, 12'h013};
    logic [7:0] lv [4] = '{8'h05, 8'h06, 8'h02, 8'h01};
    void'($urandom(32'h15638079));
    {aresetn, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
    {awaddr, araddr, wdata, wstrb} <= {12'h000, 12'h000, 32'h0, 4'hf};
    fill <= '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 14; i <= 21; i++) rc(12'(i), 32'h0);
    foreach (rw_idx[k]) begin
      v = 8'($urandom);
      wr(rw_idx[k], v);
      rc(rw_idx[k], {24'h0, v});
      if (k == 0) check({24'h0, second_xoff_character}, {24'h0, v});
    end
    v = {4'($urandom_range(2)), 4'($urandom)};
    wr(12'h014, v);
    rc(12'h014, {24'h0, v});
    check({24'h0, prescale_m_term, prescale_n_term}, {24'h0, v});
    @(posedge aclk);
    wstrb <= {3'($urandom), 1'b0};
    wr(12'h014, ~v);
    check({30'h0, bs}, {30'h0, uart_flow_pkg::resp_okay});
    rc(12'h014, {24'h0, v});
    wr(12'h030, 8'h5a);
    check({30'h0, bs}, {30'h0, uart_flow_pkg::resp_slverr});
    @(posedge aclk);
    wstrb <= 4'hf;
    wr(12'h00f, 8'hff);
    rc(12'h00f, 32'h0);
    rc(12'h030, 32'h0);
    check({30'h0, rs}, {30'h0, uart_flow_pkg::resp_slverr});
    $display("registers done");
    remote_peer_i.send_char(1'b0);
    rc(12'h00f, 32'h4);
    rc(12'h00f, 32'h0);
    remote_peer_i.send_char(1'b1);
    rc(12'h00f, 32'h8);
    remote_peer_i.set_lines(3'b011);
    rc(12'h00f, 32'h3);
    check({31'h0, tx_hold}, 32'h1);
    remote_peer_i.set_lines(3'b000);
    rc(12'h00f, 32'h0);
    wr(12'h022, 8'h08);
    remote_peer_i.send_char(1'b1);
    settle(3);
    check({31'h0, level6_irq}, 32'h1);
    rc(12'h00f, 32'h8);
    remote_peer_i.send_char(1'b0);
    settle(3);
    check({31'h0, level6_irq}, 32'h1);
    rc(12'h00f, 32'h4);
    settle(3);
    check({31'h0, level6_irq}, 32'h0);
    $display("flags done");
    r = $urandom_range(254);
    @(posedge aclk);
    fill <= {8'(r), 8'(~r), 8'h05};
    wr(12'h022, 8'h10);
    rc(12'h015, 32'(r));
    wr(12'h022, 8'h00);
    rc(12'h015, {24'h0, 8'(~r)});
    $display("fill select done");
    wr(12'h010, 8'h04);
    wr(12'h011, 8'hff);
    rc(12'h020, 32'hf);
    wr(12'h021, 8'h03);
    settle(3);
    check({31'h0, irq}, 32'h0);
    @(posedge aclk);
    fill.tx_fill <= 8'h04;
    settle(3);
    check({31'h0, irq}, 32'h1);
    rc(12'h020, 32'h1);
    wr(12'h011, 8'(r));
    rc(12'h020, 32'h3);
    wr(12'h021, 8'h04);
    settle(3);
    check({31'h0, irq}, 32'h0);
    remote_peer_i.send_char(1'b0);
    settle(3);
    check({31'h0, irq}, 32'h1);
    rc(12'h020, 32'h7);
    settle(3);
    check({31'h0, irq}, 32'h0);
    $display("interrupts done");
    wr(12'h012, 8'h02);
    wr(12'h013, 8'h06);
    wr(12'h022, 8'h03);
    e = exp_rts(8'(r), 1'b0);
    foreach (lv[k]) begin
      @(posedge aclk);
      fill.rx_fill <= lv[k];
      e = exp_rts(lv[k], e);
      settle(3);
      check({31'h0, rts_n}, {31'h0, e});
    end
    wr(12'h022, 8'h05);
    remote_peer_i.set_lines(3'b100);
    settle(3);
    check({31'h0, tx_hold}, 32'h1);
    remote_peer_i.set_lines(3'b000);
    settle(3);
    check({31'h0, tx_hold}, 32'h0);
    $display("flow control done");
    final_report();
  end
endmodule : uart_flow_regs_tb_top
